// ### bench/pwc_checker.sv
// port-level assertions of the pwm config block
`default_nettype none
module pwc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_module_offset_hit,
  input wire logic second_module_offset_hit,
  input wire logic third_module_offset_hit,
  input wire logic timer_counting_up,
  input wire logic [1:0] pwm_mode,
  input wire logic module_tick,
  input wire logic period_event,
  input wire logic load_event,
  input wire logic offset_hit,
  input wire logic timer_sync_start,
  input wire logic timer_sync_reset,
  input wire logic [15:0] lag_count,
  input wire logic buffered_output_control,
  input wire logic offset_match_direction
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready too long");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("lone error");
  // live values may only move together with a load pulse
  property p_lag_load;
    $changed(lag_count) |-> ##[0:1] load_event;
  endproperty
  a_lag_load: assert property (p_lag_load) else $error("lag moved without load");
  property p_out_load;
    $changed(buffered_output_control) |-> ##[0:1] load_event;
  endproperty
  a_out_load: assert property (p_out_load) else $error("output bit moved");
  property p_load_single;
    load_event |=> !load_event;
  endproperty
  a_load_single: assert property (p_load_single) else $error("double load");
  property p_reset_start;
    timer_sync_reset |-> timer_sync_start;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("reset without start");
  property p_start_cause;
    timer_sync_start |-> $past(first_module_offset_hit) || $past(second_module_offset_hit)
      || $past(third_module_offset_hit);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without trigger");
  // in center mode the count direction must agree with the live direction bit
  property p_center_dir;
    offset_hit && $past(pwm_mode) == 2'h3 |->
      $past(timer_counting_up) == $past(offset_match_direction);
  endproperty
  a_center_dir: assert property (p_center_dir) else $error("hit on wrong slope");
  property p_period_tick;
    period_event |-> module_tick;
  endproperty
  a_period_tick: assert property (p_period_tick) else $error("period off tick");
  c_load: cover property (load_event);
  c_sync_reset: cover property (timer_sync_reset);
  c_offset_hit: cover property (offset_hit);
  c_error: cover property (pslverr);
endmodule // pwc_checker
bind pwc_top pwc_checker pwc_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .pwm_mode(pwm_mode),
  .first_module_offset_hit(first_module_offset_hit), .module_tick(module_tick),
  .second_module_offset_hit(second_module_offset_hit), .period_event(period_event),
  .third_module_offset_hit(third_module_offset_hit), .load_event(load_event),
  .timer_counting_up(timer_counting_up), .offset_hit(offset_hit), .lag_count(lag_count),
  .timer_sync_start(timer_sync_start), .timer_sync_reset(timer_sync_reset),
  .buffered_output_control(buffered_output_control),
  .offset_match_direction(offset_match_direction));
`default_nettype wire

// ### bench/tb_pwc_top.sv
// self-checking testbench of the pwm config block
`include "pwc_defs.svh"
`default_nettype none
module tb_pwc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd_data;
  logic system_clock = 1'b1, fast_internal_osc = 1'b0, slow_internal_osc = 1'b0;
  logic sleep_mode = 1'b0, timer_counting_up = 1'b0;
  logic [15:0] module_timer = 16'h0003;
  logic [1:0] pwm_mode = 2'h0;
  logic [2:0] ld_ev = 3'h0, of_ev = 3'h0;
  logic pready, pslverr, module_tick, period_event, load_event, offset_hit;
  logic timer_sync_start, timer_sync_reset, buffered_output_control, offset_match_direction;
  logic [15:0] lag_count, duty_count, period_count, offset_count;
  logic saw_ld, saw_oh, saw_ss, saw_sr, last_err;
  int errors = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  // own index 2: the third source is this module and must stay dead
  pwc_top #(.OWN_ID(2'h2)) pwc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .system_clock(system_clock),
    .fast_internal_osc(fast_internal_osc), .slow_internal_osc(slow_internal_osc),
    .sleep_mode(sleep_mode), .module_timer(module_timer), .pwm_mode(pwm_mode),
    .timer_counting_up(timer_counting_up), .first_module_load_event(ld_ev[0]),
    .second_module_load_event(ld_ev[1]), .third_module_load_event(ld_ev[2]),
    .first_module_offset_hit(of_ev[0]), .second_module_offset_hit(of_ev[1]),
    .third_module_offset_hit(of_ev[2]), .module_tick(module_tick), .offset_hit(offset_hit),
    .period_event(period_event), .load_event(load_event), .lag_count(lag_count),
    .timer_sync_start(timer_sync_start), .timer_sync_reset(timer_sync_reset),
    .duty_count(duty_count), .period_count(period_count), .offset_count(offset_count),
    .buffered_output_control(buffered_output_control),
    .offset_match_direction(offset_match_direction));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h00_0000, a};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("BAD %0t bus timeout", $time);
      give_verdict();
    end
    rd_data = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd_data, {24'h00_0000, exp});
  endtask
  // collect the event pulses over n cycles
  task automatic watch(input int n);
    saw_ld = 1'b0;
    saw_oh = 1'b0;
    saw_ss = 1'b0;
    saw_sr = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      saw_ld |= load_event;
      saw_oh |= offset_hit;
      saw_ss |= timer_sync_start;
      saw_sr |= timer_sync_reset;
    end
  endtask
  task automatic count_ticks(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (module_tick === 1'b1) c++;
    end
  endtask
  task automatic pulse(input logic ld, input int i);
    @(posedge pclk);
    if (ld) ld_ev <= 3'h1 << i;
    else of_ev <= 3'h1 << i;
    @(posedge pclk);
    ld_ev <= 3'h0;
    of_ev <= 3'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_masks();
    for (int a = 0; a <= 'h2C; a += 4) rdchk(8'(a), 8'h00);
    apb(1'b1, `PWC_OFS_CLOCK_CTL, 8'hFF);
    rdchk(`PWC_OFS_CLOCK_CTL, 8'h73);
    apb(1'b1, `PWC_OFS_RELOAD_CTL, 8'h7F);
    rdchk(`PWC_OFS_RELOAD_CTL, 8'h43);
    apb(1'b1, `PWC_OFS_OFFSET_CTL, 8'hFF);
    rdchk(`PWC_OFS_OFFSET_CTL, 8'h73);
    apb(1'b0, 8'h34, 8'h00);
    chk(last_err, 1'b1);
    chk(rd_data, 32'h0000_0000);
    apb(1'b1, 8'hFC, 8'hFF);
    chk(last_err, 1'b1);
    for (int a = 0; a <= 8; a += 4) apb(1'b1, 8'(a), 8'h00);
  endtask
  // the prescaler counter is free running, so one tick of slack is allowed
  task automatic t_prescale();
    int c;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `PWC_OFS_CLOCK_CTL, 8'(k << 4));
      count_ticks(256, c);
      chk(c >= (256 >> k) - 1 && c <= (256 >> k) + 1, 1'b1);
    end
    apb(1'b1, `PWC_OFS_CLOCK_CTL, 8'h00);
  endtask
  // rows: expect, sleep, slow, fast, system, source code
  task automatic t_clock_source();
    logic [6:0] rows [6] = '{7'h49, 7'h52, 7'h1F, 7'h24, 7'h69, 7'h08};
    int c;
    foreach (rows[i]) begin
      apb(1'b1, `PWC_OFS_CLOCK_CTL, {6'h00, rows[i][1:0]});
      @(posedge pclk);
      system_clock <= rows[i][2];
      fast_internal_osc <= rows[i][3];
      slow_internal_osc <= rows[i][4];
      sleep_mode <= rows[i][5];
      repeat (3) @(posedge pclk);
      count_ticks(16, c);
      chk(c != 0, rows[i][6]);
    end
    apb(1'b1, `PWC_OFS_CLOCK_CTL, 8'h00);
    system_clock <= 1'b1;
    fast_internal_osc <= 1'b0;
    slow_internal_osc <= 1'b0;
    sleep_mode <= 1'b0;
  endtask
  task automatic t_immediate_reload();
    logic [7:0] wa [10] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h08};
    logic [7:0] wd [10] = '{8'h12, 8'h34, 8'hAB, 8'hCD, 8'h00, 8'h05, 8'h00, 8'h55, 8'h01, 8'h10};
    foreach (wa[i]) apb(1'b1, wa[i], wd[i]);
    rdchk(`PWC_OFS_PHASE_HI, 8'h12);
    rdchk(`PWC_OFS_DUTY_LO, 8'hCD);
    rdchk(`PWC_OFS_PERIOD_LO, 8'h05);
    chk(lag_count, 16'h0000);
    apb(1'b1, `PWC_OFS_RELOAD_CTL, 8'h80);
    watch(8);
    chk(saw_ld, 1'b0);
    rdchk(`PWC_OFS_RELOAD_CTL, 8'h80);
    @(posedge pclk);
    module_timer <= 16'h0000;
    watch(6);
    chk(saw_ld, 1'b1);
    chk({lag_count, duty_count}, 32'h1234_ABCD);
    chk({period_count, offset_count}, 32'h0005_0055);
    chk({buffered_output_control, offset_match_direction}, 2'h3);
    rdchk(`PWC_OFS_RELOAD_CTL, 8'h00);
    apb(1'b1, `PWC_OFS_RELOAD_CTL, 8'h80);
    apb(1'b1, `PWC_OFS_RELOAD_CTL, 8'h00);
    @(posedge pclk);
    module_timer <= 16'h0005;
    watch(8);
    chk(saw_ld, 1'b0);
  endtask
  // timer sits on the period, so only the trigger holds the load back
  task automatic t_triggered_reload();
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, `PWC_OFS_DUTY_LO, 8'(s + 1));
      apb(1'b1, `PWC_OFS_RELOAD_CTL, 8'(8'hC0 | s));
      watch(8);
      chk(saw_ld, 1'b0);
      chk(period_event, 1'b1);
      pulse(1'b1, (s + 1) % 3);
      watch(8);
      chk(saw_ld, 1'b0);
      pulse(1'b1, s);
      watch(8);
      chk(saw_ld, s != 2);
      chk(duty_count[7:0], (s == 2) ? 8'h02 : 8'(s + 1));
    end
    apb(1'b1, `PWC_OFS_RELOAD_CTL, 8'h00);
  endtask
  task automatic t_offset_sync();
    @(posedge pclk);
    module_timer <= 16'h0003;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 3; s++) begin
        apb(1'b1, `PWC_OFS_OFFSET_CTL, 8'((m << 5) | s));
        pulse(1'b0, s);
        watch(4);
        chk(saw_ss, m != 0 && s != 2);
        chk(saw_sr, m == 3 && s != 2);
      end
    end
  endtask
  task automatic t_center_dir();
    @(posedge pclk);
    module_timer <= 16'h0055;
    pwm_mode <= 2'h3;
    watch(8);
    chk(saw_oh, 1'b0);
    timer_counting_up <= 1'b1;
    watch(8);
    chk(saw_oh, 1'b1);
    pwm_mode <= 2'h0;
    timer_counting_up <= 1'b0;
    @(posedge pclk); // let the last up-count hit drain first
    watch(8);
    chk(saw_oh, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_masks();
    t_prescale();
    t_clock_source();
    t_immediate_reload();
    t_triggered_reload();
    t_offset_sync();
    t_center_dir();
    give_verdict();
  end
endmodule // tb_pwc_top
`default_nettype wire

// ### shared/pwc_defs.svh
// register offsets, field positions, reset values and codes of the pwm config block
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH
`define PWC_ADDR_W 8
`define PWC_OFS_CLOCK_CTL 8'h00
`define PWC_OFS_RELOAD_CTL 8'h04
`define PWC_OFS_OFFSET_CTL 8'h08
`define PWC_OFS_PHASE_HI 8'h0C
`define PWC_OFS_PHASE_LO 8'h10
`define PWC_OFS_DUTY_HI 8'h14
`define PWC_OFS_DUTY_LO 8'h18
`define PWC_OFS_PERIOD_HI 8'h1C
`define PWC_OFS_PERIOD_LO 8'h20
`define PWC_OFS_OFFSET_HI 8'h24
`define PWC_OFS_OFFSET_LO 8'h28
`define PWC_OFS_OUTPUT_CTL 8'h2C
`define PWC_OFS_STATUS 8'h30
`define PWC_CTL_RESET 8'h00
`define PWC_CNT_RESET 16'h0000
`define PWC_CLK_PS_HI 6
`define PWC_CLK_PS_LO 4
`define PWC_CLK_CS_HI 1
`define PWC_CLK_CS_LO 0
`define PWC_CLK_MASK 8'h73
`define PWC_LD_ARMED 7
`define PWC_LD_TRIG 6
`define PWC_LD_SRC_HI 1
`define PWC_LD_SRC_LO 0
`define PWC_LD_MASK 8'h43
`define PWC_OF_MODE_HI 6
`define PWC_OF_MODE_LO 5
`define PWC_OF_DIR 4
`define PWC_OF_SRC_HI 1
`define PWC_OF_SRC_LO 0
`define PWC_OF_MASK 8'h73
`define PWC_OUT_BIT 0
`define PWC_SRC_NONE 2'h3
`define PWC_MODE_CENTER 2'h3
`define PWC_DIV_W 7
`endif

// ### shared/pwc_pkg.sv
// shared types of the pwm config block
`default_nettype none
package pwc_pkg;
  typedef logic [7:0] pwc_byte_t;
  typedef logic [15:0] pwc_count_t;
  typedef enum logic [1:0] {
    pwc_ofm_indep,
    pwc_ofm_slave_run,
    pwc_ofm_one_shot,
    pwc_ofm_cont_slave
  } pwc_ofm_e;
endpackage
`default_nettype wire

// ### src/pwc_prescaler.sv
// power-of-two prescaler for the selected module clock tick
`include "pwc_defs.svh"
`default_nettype none
module pwc_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic [2:0] div_sel,
  output logic tick
);
  logic [`PWC_DIV_W-1:0] cnt_ff;
  logic tick_ff;
  // mask of ones: code n divides by 2**n, code 0 passes every tick
  wire logic [`PWC_DIV_W-1:0] mask = (`PWC_DIV_W'(1) << div_sel) - `PWC_DIV_W'(1);
  wire logic wrap = src_tick && ((cnt_ff & mask) == mask);
  wire logic [`PWC_DIV_W-1:0] nxt_cnt = src_tick ? cnt_ff + `PWC_DIV_W'(1) : cnt_ff;
  // counter free-runs on source ticks; a divider change takes effect from the next source tick, without waiting for a wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= wrap;
    end
  end
  assign tick = tick_ff;
endmodule // pwc_prescaler
`default_nettype wire

// ### src/pwc_src_sel.sv
// three-way source select with a reserved own code and reserved top code
`include "pwc_defs.svh"
`default_nettype none
module pwc_src_sel #(
  parameter logic [1:0] OWN_ID = `PWC_SRC_NONE
) (
  input wire logic [2:0] src,
  input wire logic [1:0] sel,
  output logic picked
);
  // reserved codes pick nothing so no spurious event can leak through
  wire logic reserved = (sel == `PWC_SRC_NONE) || (sel == OWN_ID);
  assign picked = reserved ? 1'b0 : src[sel];
endmodule // pwc_src_sel
`default_nettype wire

// ### src/pwc_top.sv
// register file, double buffers, reload and offset sync of one 16-bit pwm module
//
// Implementation choices: the APB slave port and the register offsets.
`include "pwc_defs.svh"
`default_nettype none
module pwc_top #(
  parameter logic [1:0] OWN_ID = `PWC_SRC_NONE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic system_clock,
  input wire logic fast_internal_osc,
  input wire logic slow_internal_osc,
  input wire logic sleep_mode,
  input wire logic [15:0] module_timer,
  input wire logic timer_counting_up,
  input wire logic [1:0] pwm_mode,
  input wire logic first_module_load_event,
  input wire logic second_module_load_event,
  input wire logic third_module_load_event,
  input wire logic first_module_offset_hit,
  input wire logic second_module_offset_hit,
  input wire logic third_module_offset_hit,
  output logic module_tick,
  output logic period_event,
  output logic load_event,
  output logic offset_hit,
  output logic timer_sync_start,
  output logic timer_sync_reset,
  output logic [15:0] lag_count,
  output logic [15:0] duty_count,
  output logic [15:0] period_count,
  output logic [15:0] offset_count,
  output logic buffered_output_control,
  output logic offset_match_direction
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte merge used by every high/low buffer half
  function automatic pwc_pkg::pwc_byte_t wr_byte(input logic hit,
                                                 input logic [31:0] data,
                                                 input pwc_pkg::pwc_byte_t old);
    wr_byte = hit ? data[7:0] : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pwrite && pready_ff;
  wire logic [`PWC_ADDR_W-1:0] addr = paddr[`PWC_ADDR_W-1:0];
  wire logic hi_zero = (paddr[31:`PWC_ADDR_W] == '0);
  wire logic sel_clk = hi_zero && (addr == `PWC_OFS_CLOCK_CTL);
  wire logic sel_ld = hi_zero && (addr == `PWC_OFS_RELOAD_CTL);
  wire logic sel_of = hi_zero && (addr == `PWC_OFS_OFFSET_CTL);
  wire logic sel_phh = hi_zero && (addr == `PWC_OFS_PHASE_HI);
  wire logic sel_phl = hi_zero && (addr == `PWC_OFS_PHASE_LO);
  wire logic sel_dch = hi_zero && (addr == `PWC_OFS_DUTY_HI);
  wire logic sel_dcl = hi_zero && (addr == `PWC_OFS_DUTY_LO);
  wire logic sel_prh = hi_zero && (addr == `PWC_OFS_PERIOD_HI);
  wire logic sel_prl = hi_zero && (addr == `PWC_OFS_PERIOD_LO);
  wire logic sel_ofh = hi_zero && (addr == `PWC_OFS_OFFSET_HI);
  wire logic sel_ofl = hi_zero && (addr == `PWC_OFS_OFFSET_LO);
  wire logic sel_out = hi_zero && (addr == `PWC_OFS_OUTPUT_CTL);
  wire logic sel_sts = hi_zero && (addr == `PWC_OFS_STATUS);
  wire logic mapped = sel_clk || sel_ld || sel_of || sel_phh || sel_phl || sel_dch ||
                      sel_dcl || sel_prh || sel_prl || sel_ofh || sel_ofl || sel_out ||
                      sel_sts;

  ////////////////////////////////////////////////////////////////////////////
  // software-visible registers

  pwc_pkg::pwc_byte_t clk_ctl_ff;
  pwc_pkg::pwc_byte_t of_ctl_ff;
  logic load_armed_ff;
  logic load_on_trigger_ff;
  logic [1:0] load_src_ff;
  pwc_pkg::pwc_count_t lag_buf_ff;
  pwc_pkg::pwc_count_t duty_buf_ff;
  pwc_pkg::pwc_count_t period_buf_ff;
  pwc_pkg::pwc_count_t offset_buf_ff;
  logic out_buf_ff;

  // control fields; masks keep unimplemented positions at zero
  wire pwc_pkg::pwc_byte_t nxt_clk_ctl = (wr_en && sel_clk) ?
                                         (pwdata[7:0] & `PWC_CLK_MASK) : clk_ctl_ff;
  wire pwc_pkg::pwc_byte_t nxt_of_ctl = (wr_en && sel_of) ?
                                        (pwdata[7:0] & `PWC_OF_MASK) : of_ctl_ff;
  wire logic [2:0] prescale_select = clk_ctl_ff[`PWC_CLK_PS_HI:`PWC_CLK_PS_LO];
  wire logic [1:0] clock_source = clk_ctl_ff[`PWC_CLK_CS_HI:`PWC_CLK_CS_LO];
  wire pwc_pkg::pwc_ofm_e offset_mode =
    pwc_pkg::pwc_ofm_e'(of_ctl_ff[`PWC_OF_MODE_HI:`PWC_OF_MODE_LO]);
  wire logic offset_dir_buf = of_ctl_ff[`PWC_OF_DIR];
  wire logic [1:0] offset_trigger_source = of_ctl_ff[`PWC_OF_SRC_HI:`PWC_OF_SRC_LO];

  // buffer writes land only in the shadow copies, never in the live counts
  wire pwc_pkg::pwc_count_t nxt_lag_buf = {wr_byte(wr_en && sel_phh, pwdata, lag_buf_ff[15:8]),
                                           wr_byte(wr_en && sel_phl, pwdata, lag_buf_ff[7:0])};
  wire pwc_pkg::pwc_count_t nxt_duty_buf = {wr_byte(wr_en && sel_dch, pwdata, duty_buf_ff[15:8]),
                                            wr_byte(wr_en && sel_dcl, pwdata, duty_buf_ff[7:0])};
  wire pwc_pkg::pwc_count_t nxt_period_buf =
    {wr_byte(wr_en && sel_prh, pwdata, period_buf_ff[15:8]),
     wr_byte(wr_en && sel_prl, pwdata, period_buf_ff[7:0])};
  wire pwc_pkg::pwc_count_t nxt_offset_buf =
    {wr_byte(wr_en && sel_ofh, pwdata, offset_buf_ff[15:8]),
     wr_byte(wr_en && sel_ofl, pwdata, offset_buf_ff[7:0])};
  wire logic nxt_out_buf = (wr_en && sel_out) ? pwdata[`PWC_OUT_BIT] : out_buf_ff;

  ////////////////////////////////////////////////////////////////////////////
  // clock source select and prescaler

  // system clock halts in sleep; both internal oscillators keep going
  wire logic sys_tick_run = system_clock && !sleep_mode;
  wire logic src_tick;
  pwc_src_sel #(.OWN_ID(`PWC_SRC_NONE)) u_clk_sel (
    .src({slow_internal_osc, fast_internal_osc, sys_tick_run}),
    .sel(clock_source),
    .picked(src_tick)
  );

  wire logic tick;
  pwc_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .div_sel(prescale_select),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // trigger selects

  wire logic load_trig;
  pwc_src_sel #(.OWN_ID(OWN_ID)) u_load_sel (
    .src({third_module_load_event, second_module_load_event, first_module_load_event}),
    .sel(load_src_ff),
    .picked(load_trig)
  );

  wire logic offset_trig;
  pwc_src_sel #(.OWN_ID(OWN_ID)) u_offset_sel (
    .src({third_module_offset_hit, second_module_offset_hit, first_module_offset_hit}),
    .sel(offset_trigger_source),
    .picked(offset_trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reload sequencing

  logic trig_seen_ff;
  logic load_event_ff;
  logic period_event_ff;
  pwc_pkg::pwc_count_t lag_live_ff;
  pwc_pkg::pwc_count_t duty_live_ff;
  pwc_pkg::pwc_count_t period_live_ff;
  pwc_pkg::pwc_count_t offset_live_ff;
  logic out_live_ff;
  logic dir_live_ff;

  // period end: timer reaches the live period on a module tick
  wire logic period_hit = tick && (module_timer == period_live_ff);
  // a trigger caught in this same cycle is only seen from the next cycle,
  // so a trigger coinciding with the period end waits one more period
  wire logic trig_ok = !load_on_trigger_ff || trig_seen_ff;
  // the armed flag is read registered, so setting it at period match defers
  wire logic do_load = period_hit && load_armed_ff && trig_ok;
  wire logic sw_ld_wr = wr_en && sel_ld;
  // software set wins over the hardware clear; software clear cancels arming
  wire logic nxt_load_armed = sw_ld_wr ? pwdata[`PWC_LD_ARMED] :
                              (do_load ? 1'b0 : load_armed_ff);
  // trigger memory lives only while armed and waiting on a trigger
  wire logic nxt_trig_seen = (!load_armed_ff || !load_on_trigger_ff || do_load) ? 1'b0 :
                             (trig_seen_ff || load_trig);

  // reload control register and trigger tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_armed_ff <= 1'b0;
      load_on_trigger_ff <= 1'b0;
      load_src_ff <= '0;
      trig_seen_ff <= 1'b0;
      load_event_ff <= 1'b0;
      period_event_ff <= 1'b0;
    end else begin
      load_armed_ff <= nxt_load_armed;
      load_on_trigger_ff <= sw_ld_wr ? pwdata[`PWC_LD_TRIG] : load_on_trigger_ff;
      load_src_ff <= sw_ld_wr ? pwdata[`PWC_LD_SRC_HI:`PWC_LD_SRC_LO] : load_src_ff;
      trig_seen_ff <= nxt_trig_seen;
      load_event_ff <= do_load;
      period_event_ff <= period_hit;
    end
  end

  // all shadow words move to the live set in one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lag_live_ff <= `PWC_CNT_RESET;
      duty_live_ff <= `PWC_CNT_RESET;
      period_live_ff <= `PWC_CNT_RESET;
      offset_live_ff <= `PWC_CNT_RESET;
      out_live_ff <= 1'b0;
      dir_live_ff <= 1'b0;
    end else if (do_load) begin
      lag_live_ff <= lag_buf_ff;
      duty_live_ff <= duty_buf_ff;
      period_live_ff <= period_buf_ff;
      offset_live_ff <= offset_buf_ff;
      out_live_ff <= out_buf_ff;
      dir_live_ff <= offset_dir_buf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offset match and slave synchronisation

  logic offset_hit_ff;
  logic sync_start_ff;
  logic sync_reset_ff;
  logic module_tick_ff;
  // direction only matters when the timer runs center-aligned
  wire logic center = (pwm_mode == `PWC_MODE_CENTER);
  wire logic dir_ok = !center || (timer_counting_up == dir_live_ff);
  wire logic nxt_offset_hit = tick && (module_timer == offset_live_ff) && dir_ok;
  wire logic slave = (offset_mode != pwc_pkg::pwc_ofm_indep);
  // start is asked for in every slave mode; the timer itself stops after
  // one period in one-shot mode, which keeps this block free of run state
  wire logic nxt_sync_start = slave && offset_trig;
  wire logic nxt_sync_reset = (offset_mode == pwc_pkg::pwc_ofm_cont_slave) && offset_trig;

  // match, sync and tick flags, each registered one pclk behind its condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_hit_ff <= 1'b0;
      sync_start_ff <= 1'b0;
      sync_reset_ff <= 1'b0;
      module_tick_ff <= 1'b0;
    end else begin
      offset_hit_ff <= nxt_offset_hit;
      sync_start_ff <= nxt_sync_start;
      sync_reset_ff <= nxt_sync_reset;
      module_tick_ff <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  // shadow buffers and control bytes; counts reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctl_ff <= `PWC_CTL_RESET;
      of_ctl_ff <= `PWC_CTL_RESET;
      lag_buf_ff <= `PWC_CNT_RESET;
      duty_buf_ff <= `PWC_CNT_RESET;
      period_buf_ff <= `PWC_CNT_RESET;
      offset_buf_ff <= `PWC_CNT_RESET;
      out_buf_ff <= 1'b0;
    end else begin
      clk_ctl_ff <= nxt_clk_ctl;
      of_ctl_ff <= nxt_of_ctl;
      lag_buf_ff <= nxt_lag_buf;
      duty_buf_ff <= nxt_duty_buf;
      period_buf_ff <= nxt_period_buf;
      offset_buf_ff <= nxt_offset_buf;
      out_buf_ff <= nxt_out_buf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and apb answer

  wire pwc_pkg::pwc_byte_t ld_rd = {load_armed_ff, load_on_trigger_ff, 4'h0, load_src_ff};
  wire pwc_pkg::pwc_byte_t sts_rd = {5'h00, trig_seen_ff, dir_live_ff, out_live_ff};
  wire pwc_pkg::pwc_byte_t rd_byte =
    sel_clk ? clk_ctl_ff :
    sel_ld  ? ld_rd :
    sel_of  ? of_ctl_ff :
    sel_phh ? lag_buf_ff[15:8] :
    sel_phl ? lag_buf_ff[7:0] :
    sel_dch ? duty_buf_ff[15:8] :
    sel_dcl ? duty_buf_ff[7:0] :
    sel_prh ? period_buf_ff[15:8] :
    sel_prl ? period_buf_ff[7:0] :
    sel_ofh ? offset_buf_ff[15:8] :
    sel_ofl ? offset_buf_ff[7:0] :
    sel_out ? {7'h00, out_buf_ff} :
    sel_sts ? sts_rd : 8'h00;

  // answer prepared in setup so the access phase completes with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      prdata_ff <= setup ? {24'h00_0000, rd_byte} : prdata_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign module_tick = module_tick_ff;
  assign period_event = period_event_ff;
  assign load_event = load_event_ff;
  assign offset_hit = offset_hit_ff;
  assign timer_sync_start = sync_start_ff;
  assign timer_sync_reset = sync_reset_ff;
  assign lag_count = lag_live_ff;
  assign duty_count = duty_live_ff;
  assign period_count = period_live_ff;
  assign offset_count = offset_live_ff;
  assign buffered_output_control = out_live_ff;
  assign offset_match_direction = dir_live_ff;

endmodule // pwc_top
`default_nettype wire
